/* rtl/pin_sync.sv */
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // Pins in, synchronised out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // Pins idle high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '1;
      dout   <= '1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // pin_sync

/* rtl/xirq_device.sv */
// External request flags, sense control, priority and standby release
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "xirq_params.svh"
module xirq_device #(
  parameter int P      = 4,
  parameter int SETTLE = `XI_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // CPU side
  xirq_if.dev               bus,
  // Pins, active low requests
  input  wire logic [11:0]  irq_pin_n,
  input  wire logic         nmi_pin,
  // Port input control, per line
  input  wire logic [11:0]  line_input_en,
  // Peripheral requests
  input  wire logic [P-1:0] periph_req
);
  localparam int CW = $clog2(SETTLE + 1);

  typedef struct packed {
    logic [11:0]             flag;
    logic [11:0]             armed;
    logic [11:0]             ssen;
    logic [23:0]             sense;
    logic [11:0]             reqen;
    logic [2:0][15:0]        prio;
    logic [7:0]              ctrl;
    logic [11:0]             dtcen;
    logic                    xerr;
    logic [P-1:0]            perien;
    logic [12:0]             prev;
    logic                    nmi_pend;
    xirq_pkg::word_t         rdata;
    logic                    irq_req;
    xirq_pkg::line_t         irq_line;
    xirq_pkg::level_t        irq_level;
    logic                    dtc_req;
    xirq_pkg::line_t         dtc_line;
    xirq_pkg::wake_st_t      wst;
    logic [CW-1:0]           cnt;
    logic                    wake;
  } st_t;

  st_t          s_q;
  st_t          s_d;
  logic [12:0]  pins_s;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two flops first
  pin_sync #(.W(13)) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     ({nmi_pin, irq_pin_n}),
    .dout    (pins_s)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Event per sense mode
  function automatic logic fire(input xirq_pkg::sense_t m, input logic pv, input logic cu);
    case (m)
      xirq_pkg::SENSE_LOW:  fire = !cu;
      xirq_pkg::SENSE_FALL: fire = pv && !cu;
      xirq_pkg::SENSE_RISE: fire = !pv && cu;
      default:              fire = pv ^ cu;
    endcase
  endfunction

  function automatic xirq_pkg::level_t lvl(input logic [2:0][15:0] pr, input int n);
    lvl = pr[n / 4][(n % 4) * 4 +: 3];
  endfunction

  function automatic xirq_pkg::word_t rmux(input st_t s, input logic [3:0] a);
    case (a)
      `XI_A_FLAGS:    rmux = {4'h0, s.flag};
      `XI_A_SSEN:     rmux = {4'h0, s.ssen};
      `XI_A_SENSE_LO: rmux = s.sense[15:0];
      `XI_A_SENSE_HI: rmux = {8'h00, s.sense[23:16]};
      `XI_A_REQEN:    rmux = {4'h0, s.reqen};
      `XI_A_PRIO0:    rmux = s.prio[0];
      `XI_A_PRIO1:    rmux = s.prio[1];
      `XI_A_PRIO2:    rmux = s.prio[2];
      `XI_A_CTRL:     rmux = {8'h00, s.ctrl};
      `XI_A_DTCEN:    rmux = {4'h0, s.dtcen};
      `XI_A_XFER:     rmux = {15'h0000, s.xerr};
      `XI_A_PERIEN:   rmux = 16'(s.perien);
      default:        rmux = 16'h0000;
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [11:0]       ev;
    logic [11:0]       set;
    logic [11:0]       clr;
    logic [11:0]       pend;
    logic              nmi_ev;
    logic              peri_pend;
    logic              peri_dtc;
    logic              found;
    logic              wr;
    xirq_pkg::level_t  best;
    xirq_pkg::level_t  plvl;
    xirq_pkg::sense_t  m;
    ev        = '0;
    set       = '0;
    clr       = '0;
    pend      = '0;
    nmi_ev    = 1'b0;
    peri_pend = 1'b0;
    peri_dtc  = 1'b0;
    found     = 1'b0;
    best      = '0;
    m         = xirq_pkg::SENSE_LOW;
    s_d       = s_q;
    wr        = bus.wr;
    plvl      = s_q.ctrl[`XI_CTRL_PLVL +: 3];
    s_d.prev  = pins_s;
    for (int n = 0; n < `XI_NLINES; n++) begin
      m     = xirq_pkg::sense_t'(s_q.sense[2 * n +: 2]);
      ev[n] = fire(m, s_q.prev[n], pins_s[n]) && line_input_en[n];
      if (bus.exc_ack && !bus.exc_nmi && bus.ack_line == 4'(n)) begin
        if (m == xirq_pkg::SENSE_LOW) clr[n] = pins_s[n];
        else clr[n] = 1'b1;
      end
      if (bus.dtc_ack && !bus.transfer_interrupt_select && bus.ack_line == 4'(n)) clr[n] = 1'b1;
    end
    // Only enabled lines sampled in standby
    set = bus.standby ? (ev & s_q.ssen) : ev;
    if (wr && bus.addr == `XI_A_FLAGS) clr = clr | (s_q.armed & ~bus.wdata[11:0]);
    // Set wins over clear
    s_d.flag  = (s_q.flag & ~clr) | set;
    s_d.armed = ((bus.rd && bus.addr == `XI_A_FLAGS) ? (s_q.armed | s_q.flag) : s_q.armed) & s_d.flag;
    nmi_ev = s_q.ctrl[`XI_CTRL_NONMASKABLE_EDGE_SELECT] ? (!s_q.prev[12] && pins_s[12]) : (s_q.prev[12] && !pins_s[12]);
    s_d.nmi_pend = (s_q.nmi_pend && !(bus.exc_ack && bus.exc_nmi)) || nmi_ev;
    // Register writes, reserved bits kept zero
    if (wr) begin
      case (bus.addr)
        `XI_A_SSEN:     s_d.ssen  = bus.wdata[11:0];
        `XI_A_SENSE_LO: s_d.sense[15:0] = bus.wdata;
        `XI_A_SENSE_HI: s_d.sense[23:16] = bus.wdata[7:0];
        `XI_A_REQEN:    s_d.reqen = bus.wdata[11:0];
        `XI_A_PRIO0:    s_d.prio[0] = bus.wdata & `XI_PRIO_MASK;
        `XI_A_PRIO1:    s_d.prio[1] = bus.wdata & `XI_PRIO_MASK;
        `XI_A_PRIO2:    s_d.prio[2] = bus.wdata & `XI_PRIO_MASK;
        `XI_A_CTRL:     s_d.ctrl  = bus.wdata[7:0];
        `XI_A_DTCEN:    s_d.dtcen = bus.wdata[11:0];
        `XI_A_XFER:     s_d.xerr  = bus.wdata[`XI_XFER_ERR];
        `XI_A_PERIEN:   s_d.perien = bus.wdata[P-1:0];
        default:        ;
      endcase
    end
    if (nmi_ev) s_d.xerr = 1'b1;
    // Enabled and not steered to transfer
    pend = s_q.flag & s_q.reqen & ~s_q.dtcen;
    s_d.irq_line = '0;
    for (int n = 0; n < `XI_NLINES; n++) begin
      if (pend[n] && (!found || lvl(s_q.prio, n) > best)) begin
        found        = 1'b1;
        best         = lvl(s_q.prio, n);
        s_d.irq_line = 4'(n);
      end
    end
    peri_pend = |(periph_req & s_q.perien);
    peri_dtc  = peri_pend && s_q.ctrl[`XI_CTRL_PCE] && plvl >= s_q.ctrl[`XI_CTRL_DTP +: 3];
    if (peri_pend && !peri_dtc && (!found || plvl > best)) begin
      found        = 1'b1;
      best         = plvl;
      s_d.irq_line = `XI_PERI_LINE;
    end
    s_d.irq_req   = found;
    s_d.irq_level = best;
    // Transfer requests, lowest line first
    s_d.dtc_req  = 1'b0;
    s_d.dtc_line = '0;
    for (int n = `XI_NLINES - 1; n >= 0; n--) begin
      if (s_q.flag[n] && s_q.reqen[n] && s_q.dtcen[n]) begin
        s_d.dtc_req  = 1'b1;
        s_d.dtc_line = 4'(n);
      end
    end
    if (!s_d.dtc_req && peri_dtc) begin
      s_d.dtc_req  = 1'b1;
      s_d.dtc_line = `XI_PERI_LINE;
    end
    // Read data stand one cycle
    s_d.rdata = bus.rd ? rmux(s_q, bus.addr) : 16'h0000;
    case (s_q.wst)
      xirq_pkg::WAKE_IDLE: begin
        if (bus.standby && (|(ev & s_q.ssen) || nmi_ev)) begin
          s_d.wst = xirq_pkg::WAKE_SETTLE;
          s_d.cnt = CW'(SETTLE - 1);
        end
      end
      xirq_pkg::WAKE_SETTLE: begin
        if (s_q.cnt == '0) begin
          s_d.wst  = xirq_pkg::WAKE_DONE;
          s_d.wake = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - CW'(1);
        end
      end
      xirq_pkg::WAKE_DONE: begin
        if (!bus.standby) begin
          s_d.wst  = xirq_pkg::WAKE_IDLE;
          s_d.wake = 1'b0;
        end
      end
      default: s_d.wst = xirq_pkg::WAKE_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q      <= '0;
      s_q.prev <= '1;
      s_q.wst  <= xirq_pkg::WAKE_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from state flops
  assign bus.rdata     = s_q.rdata;
  assign bus.irq_req   = s_q.irq_req;
  assign bus.irq_line  = s_q.irq_line;
  assign bus.irq_level = s_q.irq_level;
  assign bus.nmi_req   = s_q.nmi_pend;
  assign bus.dtc_req   = s_q.dtc_req;
  assign bus.dtc_line  = s_q.dtc_line;
  assign bus.wake      = s_q.wake;
endmodule // xirq_device

/* rtl/xirq_host.sv */
// CPU and transfer side: forwards register access and acknowledges requests
`timescale 1ns/10ps
`include "xirq_params.svh"
module xirq_host (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // Device side
  xirq_if.host                  bus,
  // Software port
  input  wire logic [4:0]       sw_addr,
  input  wire xirq_pkg::word_t  sw_wdata,
  input  wire logic             sw_wr,
  input  wire logic             sw_rd,
  output xirq_pkg::word_t       sw_rdata
);
  typedef struct packed {
    logic [4:0]       ctrl;
    xirq_pkg::line_t  last_line;
    logic             last_nmi;
    logic             last_dtc;
    logic             exc_ack;
    logic             exc_nmi;
    logic             dtc_ack;
    xirq_pkg::line_t  ack_line;
    logic [1:0]       hold;
    logic             dev_rd;
    xirq_pkg::word_t  own_rdata;
  } st_t;

  st_t s_q;
  st_t s_d;

  // Low half of the map reaches the device directly
  assign bus.addr  = sw_addr[3:0];
  assign bus.wdata = sw_wdata;
  assign bus.wr    = sw_wr && !sw_addr[4];
  assign bus.rd    = sw_rd && !sw_addr[4];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d           = s_q;
    s_d.exc_ack   = 1'b0;
    s_d.exc_nmi   = 1'b0;
    s_d.dtc_ack   = 1'b0;
    s_d.dev_rd    = sw_rd && !sw_addr[4];
    s_d.own_rdata = 16'h0000;
    if (sw_rd && sw_addr == `HO_A_CTRL) s_d.own_rdata = {11'h000, s_q.ctrl};
    if (sw_rd && sw_addr == `HO_A_STAT) s_d.own_rdata = {9'h000, bus.standby, s_q.last_dtc, s_q.last_nmi, s_q.last_line};
    if (sw_wr && sw_addr == `HO_A_CTRL) s_d.ctrl = sw_wdata[4:0];
    // Release ends standby
    if (bus.wake) s_d.ctrl[`HO_CTRL_STBY] = 1'b0;
    // Wait for device to show the cleared flag
    if (s_q.hold != 2'h0) begin
      s_d.hold = s_q.hold - 2'h1;
    end else if (bus.nmi_req) begin
      s_d.exc_ack  = 1'b1;
      s_d.exc_nmi  = 1'b1;
      s_d.last_nmi = 1'b1;
      s_d.last_dtc = 1'b0;
      s_d.hold     = `HO_HOLD;
    end else if (bus.dtc_req) begin
      s_d.dtc_ack   = 1'b1;
      s_d.ack_line  = bus.dtc_line;
      s_d.last_line = bus.dtc_line;
      s_d.last_nmi  = 1'b0;
      s_d.last_dtc  = 1'b1;
      s_d.hold      = `HO_HOLD;
    end else if (bus.irq_req && bus.irq_level > s_q.ctrl[`HO_CTRL_MASK +: 3]) begin
      s_d.exc_ack   = 1'b1;
      s_d.ack_line  = bus.irq_line;
      s_d.last_line = bus.irq_line;
      s_d.last_nmi  = 1'b0;
      s_d.last_dtc  = 1'b0;
      s_d.hold      = `HO_HOLD;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Acknowledges and standby from flops
  assign bus.exc_ack  = s_q.exc_ack;
  assign bus.exc_nmi  = s_q.exc_nmi;
  assign bus.dtc_ack  = s_q.dtc_ack;
  assign bus.ack_line = s_q.ack_line;
  assign bus.transfer_interrupt_select    = s_q.ctrl[`HO_CTRL_TRANSFER_INTERRUPT_SELECT];
  assign bus.standby  = s_q.ctrl[`HO_CTRL_STBY];
  assign sw_rdata     = s_q.dev_rd ? bus.rdata : s_q.own_rdata;
endmodule // xirq_host

/* rtl/xirq_if.sv */
// Carrier between the request block and the CPU and transfer side
`timescale 1ns/10ps
interface xirq_if;
  // Register access
  logic [3:0]        addr;
  xirq_pkg::word_t   wdata;
  logic              wr;
  logic              rd;
  xirq_pkg::word_t   rdata;
  // Requests towards CPU and transfer controller
  logic              irq_req;
  xirq_pkg::line_t   irq_line;
  xirq_pkg::level_t  irq_level;
  logic              nmi_req;
  logic              dtc_req;
  xirq_pkg::line_t   dtc_line;
  // Acknowledges back
  logic              exc_ack;
  logic              exc_nmi;
  logic              dtc_ack;
  xirq_pkg::line_t   ack_line;
  logic              transfer_interrupt_select;
  // Standby
  logic              standby;
  logic              wake;

  modport dev (input addr, wdata, wr, rd, exc_ack, exc_nmi, dtc_ack, ack_line, transfer_interrupt_select, standby,
               output rdata, irq_req, irq_line, irq_level, nmi_req, dtc_req, dtc_line, wake);
  modport host (output addr, wdata, wr, rd, exc_ack, exc_nmi, dtc_ack, ack_line, transfer_interrupt_select, standby,
                input rdata, irq_req, irq_line, irq_level, nmi_req, dtc_req, dtc_line, wake);
endinterface

/* rtl/xirq_params.svh */
// Offsets, field positions, masks and timing counts of the external request block
// Overview of operation
// - Sensed pin event sets line request flag
// - Flag cleared by 0 after read; 1 ignored
// - Low-level: handling clears flag if pin high
// - Edge modes: handling always clears flag
// - Transfer start clears flag if select 0
// - Bits 15 to 12 read zero
// - Disabled lines not sampled in standby
// - Enabled line leaves standby after settling
// - Software keeps wake lines off transfer
// - Nonmaskable request highest, always accepted
// - Nonmaskable edge chosen by select bit
// - Nonmaskable request sets transfer error bit
// - Low, falling, rising or both edges
// - Sense codes 00 low to 11 both
// - Request reaches CPU only when enabled
// - Each line has programmable priority level
// - Ties keep lower index first
// - Detection gated only by input control
// - Source holds low level until handling
// - Peripheral request forwarded only when enabled
// - Peripheral transfer start gated by priority bits
// - All thirteen sources can end standby
`ifndef XIRQ_PARAMS_SVH
`define XIRQ_PARAMS_SVH
`define XI_NLINES       12
`define XI_A_FLAGS      4'h0
`define XI_A_SSEN       4'h1
`define XI_A_SENSE_LO   4'h2
`define XI_A_SENSE_HI   4'h3
`define XI_A_REQEN      4'h4
`define XI_A_PRIO0      4'h5
`define XI_A_PRIO1      4'h6
`define XI_A_PRIO2      4'h7
`define XI_A_CTRL       4'h8
`define XI_A_DTCEN      4'h9
`define XI_A_XFER       4'ha
`define XI_A_PERIEN     4'hb
`define XI_LINE_MASK    16'h0fff
`define XI_PRIO_MASK    16'h7777
`define XI_CTRL_MASK    16'h00ff
`define XI_SENSE_HI_MSK 16'h00ff
`define XI_CTRL_NONMASKABLE_EDGE_SELECT   0
`define XI_CTRL_PCE     1
`define XI_CTRL_DTP     2
`define XI_CTRL_PLVL    5
`define XI_XFER_ERR     0
`define XI_PERI_LINE    4'hc
`define XI_SETTLE_NS    1000
`define XI_CLK_NS       20
`define XI_SETTLE_CYC   ((`XI_SETTLE_NS + `XI_CLK_NS - 1) / `XI_CLK_NS)
`define HO_A_CTRL       5'h10
`define HO_A_STAT       5'h11
`define HO_CTRL_STBY    0
`define HO_CTRL_MASK    1
`define HO_CTRL_TRANSFER_INTERRUPT_SELECT   4
`define HO_CTRL_MSK     16'h001f
`define HO_HOLD         2'h2
`endif

/* rtl/xirq_pkg.sv */
// Types shared by both ends of the external request block
package xirq_pkg;
  // Sense field encoding, in order 00 to 11
  typedef enum logic [1:0] {SENSE_LOW, SENSE_FALL, SENSE_RISE, SENSE_BOTH} sense_t;
  // Standby release sequencer
  typedef enum logic [1:0] {WAKE_IDLE, WAKE_SETTLE, WAKE_DONE} wake_st_t;
  typedef logic [2:0] level_t;
  typedef logic [3:0] line_t;
  typedef logic [15:0] word_t;
endpackage

/* sim/external_irq_status_standby_release_tb.sv */
// Self-checking bench for the request block with both ends joined
`timescale 1ns/10ps
module external_irq_status_standby_release_tb;
  localparam int SETTLE_SIM = 4;
  // Clock, reset and software port
  logic            clk_sys;
  logic            arst_n;
  logic [4:0]      sw_addr;
  xirq_pkg::word_t sw_wdata;
  logic            sw_wr;
  logic            sw_rd;
  xirq_pkg::word_t sw_rdata;
  // Pins and side inputs
  logic [11:0]     irq_pin_n;
  logic            nmi_pin;
  logic [11:0]     line_input_en;
  logic [3:0]      periph_req;
  int              mismatches;
  int              n_compared;

  xirq_if u_xirq_if ();

  xirq_device #(.P(4), .SETTLE(SETTLE_SIM)) u_xirq_device (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(u_xirq_if), .irq_pin_n(irq_pin_n),
    .nmi_pin(nmi_pin), .line_input_en(line_input_en), .periph_req(periph_req));

  xirq_host u_xirq_host (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(u_xirq_if), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));

  xirq_monitor #(.SETTLE(SETTLE_SIM)) u_xirq_monitor (
    .clk_sys(clk_sys), .arst_n(arst_n), .addr(u_xirq_if.addr), .rd(u_xirq_if.rd),
    .rdata(u_xirq_if.rdata), .irq_req(u_xirq_if.irq_req), .irq_line(u_xirq_if.irq_line),
    .nmi_req(u_xirq_if.nmi_req), .dtc_req(u_xirq_if.dtc_req), .dtc_line(u_xirq_if.dtc_line),
    .exc_ack(u_xirq_if.exc_ack), .exc_nmi(u_xirq_if.exc_nmi), .dtc_ack(u_xirq_if.dtc_ack),
    .standby(u_xirq_if.standby), .wake(u_xirq_if.wake));

  // Clock generator, 20 ns period
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic sw_write(input logic [4:0] a, input xirq_pkg::word_t d);
    @(posedge clk_sys);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk_sys);
    sw_wr    <= 1'b0;
  endtask

  // Read, data taken in the cycle after the strobe, masked compare
  task automatic rd_chk(input logic [4:0] a, input xirq_pkg::word_t exp, input string what,
                        input xirq_pkg::word_t mask = 16'hffff);
    xirq_pkg::word_t d;
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk_sys);
    sw_rd   <= 1'b0;
    #1;
    d = sw_rdata & mask;
    n_compared++;
    if (d !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, d);
    end
  endtask

  // Drives the request pins, then lets them pass the synchroniser
  task automatic set_pins(input logic [11:0] v, input int n);
    @(posedge clk_sys);
    irq_pin_n <= v;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic set_nmi(input logic v);
    @(posedge clk_sys);
    nmi_pin <= v;
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    mismatches = 0;
    n_compared = 0;
    arst_n = 1'b0;
    sw_addr = 5'h00;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    irq_pin_n = 12'hfff;
    nmi_pin = 1'b1;
    line_input_en = 12'hfef;
    periph_req = 4'h0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset values, reserved bits, unmapped places
    rd_chk(5'h00, 16'h0000, "flags reset");
    rd_chk(5'h01, 16'h0000, "release reset");
    sw_write(5'h01, 16'h0fff);
    rd_chk(5'h01, 16'h0fff, "release top bits");
    sw_write(5'h01, 16'h0000);
    sw_write(5'h0c, 16'hffff);
    rd_chk(5'h0c, 16'h0000, "unmapped device");
    rd_chk(5'h12, 16'h0000, "unmapped host");
    $display("test registers done");
    // Lines 0..3 low, fall, rise, both; line 4 fall but input gated off
    sw_write(5'h02, 16'h45e4);
    set_pins(12'hfe0, 12);
    rd_chk(5'h00, 16'h000b, "flags after fall");
    set_pins(12'hfff, 12);
    sw_write(5'h00, 16'h0fff);
    rd_chk(5'h00, 16'h000f, "flags after rise");
    sw_write(5'h00, 16'h0000);
    rd_chk(5'h00, 16'h0000, "flags cleared");
    $display("test sense done");
    // Lines 5 and 6 at level 1, enabled towards the CPU
    sw_write(5'h06, 16'h0110);
    sw_write(5'h04, 16'h0060);
    set_pins(12'hfdf, 12);
    rd_chk(5'h00, 16'h0000, "edge flag after handling");
    rd_chk(5'h11, 16'h0005, "handled line 5");
    set_pins(12'hfbf, 10);
    set_pins(12'hfff, 12);
    rd_chk(5'h00, 16'h0000, "level flag after handling");
    rd_chk(5'h11, 16'h0006, "handled line 6");
    $display("test handling done");
    // Line 7 routed to transfer, select bit 0 then 1
    sw_write(5'h04, 16'h00e0);
    sw_write(5'h09, 16'h0080);
    set_pins(12'hf7f, 12);
    rd_chk(5'h00, 16'h0000, "flag after transfer");
    rd_chk(5'h11, 16'h0027, "transfer line 7");
    sw_write(5'h10, 16'h0010);
    set_pins(12'hfff, 6);
    set_pins(12'hf7f, 12);
    rd_chk(5'h00, 16'h0080, "flag kept by select");
    sw_write(5'h00, 16'h0000);
    // Wake lines kept off transfer
    sw_write(5'h09, 16'h0000);
    set_pins(12'hfff, 6);
    $display("test transfer done");
    // Nonmaskable on falling then rising edge
    set_nmi(1'b0);
    rd_chk(5'h0a, 16'h0001, "error after falling nmi");
    rd_chk(5'h11, 16'h0010, "nmi handled", 16'h0010);
    sw_write(5'h0a, 16'h0000);
    rd_chk(5'h0a, 16'h0000, "error cleared");
    sw_write(5'h08, 16'h0001);
    set_nmi(1'b1);
    rd_chk(5'h0a, 16'h0001, "error after rising nmi");
    sw_write(5'h0a, 16'h0000);
    set_nmi(1'b0);
    rd_chk(5'h0a, 16'h0000, "falling ignored in rise mode");
    $display("test nmi done");
    // Standby: line 10 not released, line 9 released
    sw_write(5'h03, 16'h0014);
    sw_write(5'h01, 16'h0200);
    sw_write(5'h10, 16'h0001);
    set_pins(12'hbff, 12);
    rd_chk(5'h00, 16'h0000, "disabled line in standby");
    rd_chk(5'h10, 16'h0001, "still in standby");
    set_pins(12'hfff, 6);
    set_pins(12'hdff, 20);
    rd_chk(5'h00, 16'h0200, "release line flag");
    rd_chk(5'h10, 16'h0000, "left standby on line");
    sw_write(5'h00, 16'h0000);
    set_pins(12'hfff, 6);
    sw_write(5'h10, 16'h0001);
    set_nmi(1'b1);
    repeat (10) @(posedge clk_sys);
    rd_chk(5'h10, 16'h0000, "left standby on nmi");
    $display("test standby done");
    // Peripheral request at level 1, enable off then on
    sw_write(5'h08, 16'h0021);
    @(posedge clk_sys);
    periph_req <= 4'h1;
    repeat (10) @(posedge clk_sys);
    rd_chk(5'h11, 16'h0010, "peripheral held back", 16'h0010);
    sw_write(5'h0b, 16'h0001);
    repeat (10) @(posedge clk_sys);
    rd_chk(5'h11, 16'h000c, "peripheral handled");
    @(posedge clk_sys);
    periph_req <= 4'h0;
    $display("test peripheral done");
    end_sim();
  end

  // Watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim();
  end
endmodule // external_irq_status_standby_release_tb

/* sim/xirq_monitor.sv */
// Concurrent checks on the carrier between the two request block ends
`timescale 1ns/10ps
module xirq_monitor #(
  parameter int SETTLE = 4
) (
  // Clock and reset
  input wire logic            clk_sys,
  input wire logic            arst_n,
  // Register access
  input wire logic [3:0]      addr,
  input wire logic            rd,
  input wire xirq_pkg::word_t rdata,
  // Requests
  input wire logic            irq_req,
  input wire xirq_pkg::line_t irq_line,
  input wire logic            nmi_req,
  input wire logic            dtc_req,
  input wire xirq_pkg::line_t dtc_line,
  // Acknowledges and standby
  input wire logic            exc_ack,
  input wire logic            exc_nmi,
  input wire logic            dtc_ack,
  input wire logic            standby,
  input wire logic            wake
);
  logic [7:0] stby_cnt_q;
  logic [7:0] stby_cnt_d;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Counts cycles spent in standby, saturating
  always_comb begin
    stby_cnt_d = 8'h00;
    if (standby) begin
      stby_cnt_d = (stby_cnt_q == 8'hff) ? stby_cnt_q : stby_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stby_cnt_q <= 8'h00;
    end else begin
      stby_cnt_q <= stby_cnt_d;
    end
  end

  // Acknowledge pulse and the quiet gap after it
  sequence s_ack;
    exc_ack || dtc_ack;
  endsequence
  sequence s_quiet2;
    !(exc_ack || dtc_ack) [*2];
  endsequence

  chk_flag_top_zero: assert property (rd && addr == 4'h0 |=> rdata[15:12] == 4'h0)
    else $error("flag word top bits not zero");
  chk_wake_top_zero: assert property (rd && addr == 4'h1 |=> rdata[15:12] == 4'h0)
    else $error("release word top bits not zero");
  chk_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_nmi_first: assert property (exc_ack && $past(nmi_req) |-> exc_nmi)
    else $error("pending nonmaskable request passed over");
  chk_nmi_held: assert property (nmi_req && !(exc_ack && exc_nmi) |=> nmi_req)
    else $error("nonmaskable request dropped before acceptance");
  chk_nmi_with_ack: assert property (exc_nmi |-> exc_ack)
    else $error("nonmaskable flag without acknowledge");
  chk_ack_gap: assert property (s_ack |=> s_quiet2)
    else $error("acknowledges closer than three cycles");
  chk_wake_settle: assert property ($rose(wake) |-> stby_cnt_q >= 8'(SETTLE))
    else $error("wake before settling time");
  chk_wake_drop: assert property (!standby |=> !wake)
    else $error("wake held outside standby");
  chk_line_range: assert property (irq_req |-> irq_line <= 4'hc)
    else $error("request line out of range");
  chk_xfer_range: assert property (dtc_req |-> dtc_line <= 4'hc)
    else $error("transfer line out of range");
endmodule // xirq_monitor
